// >>> rtl/sfpp_buf.sv
/*
  Sector data buffer: 128 bytes, one write port, one registered read port.
  Assumes the reader allows one cycle from address to data.
*/
`timescale 1ns/1ps
module sfpp_buf (
  input wire logic pclk,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [6:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [6:0] rd_idx,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:127];

  always_ff @(posedge pclk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_idx] <= wr_data;
      end
      rd_data <= mem[rd_idx];
    end
  end
endmodule : sfpp_buf

// >>> rtl/sfpp_ctrl.sv
/*
  Host-side controller for a byte-wide sector-programmed flash: APB register
  file, protected sector load, toggle-bit completion polling, product ID read.
  Assumes flash inputs are synchronous to pclk and the flash is on alone.
*/
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Output enable high while write strobes low
// R2 - Same sector address at every strobe fall
// R3 - Unloaded sector bytes end up undefined
// R4 - Device relocks after each program cycle
// R5 - Always load all 128 bytes
// R6 - Byte loads spaced under load timeout
// R7 - Toggling output enable yields toggle status
// R8 - Only toggle bit change matters, not value
// R9 - Polling address held constant
// R10 - Device leaves ID mode at power loss
// R11 - ID read: address bit 0 picks code
// R12 - Exit sequence restores normal array operation
// R13 - Device erases then programs by itself
// R14 - Poll bit reads complement while busy
// R15 - Command prefix first, no access until done
module sfpp_ctrl
  import sfpp_pkg::*;
#(
  parameter int PROG_TIMEOUT_CYC = TWC_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_i,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sfpp_state_e state;
    sfpp_op_e op;
    logic [7:0] step;
    logic [11:0] cnt;
    logic [18:0] tmo;
    logic polling;
    logic have_prev;
    logic prev_t;
    logic [15:0] ctl_addr;
    logic [6:0] bidx;
    logic [7:0] rbyte;
    logic [7:0] maker;
    logic [7:0] part;
    logic [2:0] istat;
    logic [2:0] imask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [15:0] f_addr;
    logic [7:0] f_dq;
    logic f_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } sfpp_st_s;

  sfpp_st_s st_reg;
  sfpp_st_s st_next;
  logic [7:0] buf_rd_data;
  logic [7:0] data_idx;
  logic acc_wr;
  logic acc_rd;
  logic busy;
  logic buf_wr;
  logic [2:0] ev;

  assign busy = (st_reg.state != S_IDLE);
  assign acc_wr = psel && penable && st_reg.pready && pwrite;
  assign acc_rd = psel && penable && st_reg.pready && !pwrite;
  // Buffer is frozen while an operation runs
  assign buf_wr = acc_wr && (paddr == REG_BUFDATA) && !busy;
  assign data_idx = st_reg.step - STEP_DATA0;

  sfpp_buf sfpp_buf_i (
    .pclk(pclk),
    .clk_en(clk_en),
    .wr_en(buf_wr),
    .wr_idx(st_reg.bidx),
    .wr_data(pwdata[7:0]),
    .rd_idx(data_idx[6:0]),
    .rd_data(buf_rd_data)
  );

  // ----------------------------------------------------------------
  // Step decode
  // ----------------------------------------------------------------
  function automatic logic step_is_read(sfpp_op_e op, logic [7:0] step);
    step_is_read = (op == OP_READ) ||
                   ((op == OP_ID) && (step == STEP_ID_MAKER || step == STEP_ID_PART));
  endfunction : step_is_read

  function automatic logic [7:0] step_end(sfpp_op_e op);
    unique case (op)
      OP_PROG: step_end = STEP_PROG_END;
      OP_ID: step_end = STEP_ID_END;
      default: step_end = STEP_RD_END;
    endcase
  endfunction : step_end

  // Three-write unlock prefix, shared by protect, ID entry and ID exit
  function automatic logic [15:0] cmd_addr(logic [7:0] k);
    cmd_addr = (k == 8'h01) ? CMD_ADDR_B : CMD_ADDR_A;
  endfunction : cmd_addr

  function automatic logic [7:0] cmd_data(logic [7:0] k, logic [7:0] last);
    unique case (k)
      8'h00: cmd_data = CMD_UNLOCK_A;
      8'h01: cmd_data = CMD_UNLOCK_B;
      default: cmd_data = last;
    endcase
  endfunction : cmd_data

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] nstep;
    logic sample;
    nstep = st_reg.step + 8'h01;
    sample = 1'b0;
    ev = 3'h0;
    st_next = st_reg;
    st_next.pready = psel && !penable && !st_reg.pready;
    st_next.pslverr = 1'b0;

    // APB register access
    if (psel && !penable && !st_reg.pready) begin
      st_next.prdata = 32'h0000_0000;
      unique case (paddr)
        REG_CMD, REG_BUFDATA: st_next.prdata = 32'h0000_0000;
        REG_ADDR: st_next.prdata = {16'h0000, st_reg.ctl_addr};
        REG_BUFIDX: st_next.prdata = {25'h0, st_reg.bidx};
        REG_STATUS: st_next.prdata = {29'h0, st_reg.polling, st_reg.op == OP_PROG, busy};
        REG_RDATA: st_next.prdata = {8'h00, st_reg.part, st_reg.maker, st_reg.rbyte};
        REG_ISTAT: st_next.prdata = {29'h0, st_reg.istat};
        REG_IMASK: st_next.prdata = {29'h0, st_reg.imask};
        default: st_next.pslverr = 1'b1;
      endcase
    end else if (st_reg.pready) begin
      st_next.pslverr = st_reg.pslverr;
    end
    if (acc_wr && !busy) begin
      unique case (paddr)
        REG_ADDR: st_next.ctl_addr = pwdata[15:0];
        REG_BUFIDX: st_next.bidx = pwdata[6:0];
        REG_BUFDATA: st_next.bidx = st_reg.bidx + 7'h01;
        default: ;
      endcase
    end
    if (acc_wr && paddr == REG_IMASK) begin
      st_next.imask = pwdata[2:0];
    end
    if (acc_wr && paddr == REG_CMD) begin
      if (busy || pwdata[1:0] == 2'h0) begin
        ev[IRQ_REFUSED] = 1'b1;
      end else begin
        st_next.op = (pwdata[1:0] == OPC_PROG) ? OP_PROG :
                     (pwdata[1:0] == OPC_ID) ? OP_ID : OP_READ;
        st_next.step = 8'h00;
        st_next.cnt = 12'h000;
        st_next.tmo = 19'h0;
        st_next.polling = 1'b0;
        st_next.have_prev = 1'b0;
        st_next.ce_n = 1'b0;
        st_next.state = (pwdata[1:0] == OPC_READ) ? S_RLOW : S_WSET;
      end
    end

    // Flash sequencer
    unique case (st_reg.state)
      S_IDLE: ;
      S_WSET: begin
        st_next.cnt = st_reg.cnt + 12'h001;
        st_next.oe_n = 1'b1;
        if (st_reg.op == OP_PROG && st_reg.step >= STEP_DATA0) begin
          st_next.f_addr = {st_reg.ctl_addr[15:SECT_LSB], data_idx[6:0]}; // R2
          st_next.f_dq = buf_rd_data;
        end else if (st_reg.op == OP_PROG) begin
          st_next.f_addr = cmd_addr(st_reg.step); // R15
          st_next.f_dq = cmd_data(st_reg.step, CMD_PROTECT);
        end else begin
          st_next.f_addr = cmd_addr(st_reg.step > STEP_ID_PART ? st_reg.step - 8'h05 : st_reg.step);
          st_next.f_dq = (st_reg.step > STEP_ID_PART) ?
                         cmd_data(st_reg.step - 8'h05, CMD_ID_EXIT) : // R12
                         cmd_data(st_reg.step, CMD_ID_ENTRY);
        end
        st_next.f_oe = 1'b1;
        if (st_reg.cnt == SET_CYC - 12'h001) begin
          st_next.cnt = 12'h000;
          st_next.we_n = 1'b0; // R1
          st_next.state = S_WLOW;
        end
      end
      S_WLOW: begin
        st_next.cnt = st_reg.cnt + 12'h001;
        if (st_reg.cnt == WP_CYC - 12'h001) begin
          st_next.cnt = 12'h000;
          st_next.we_n = 1'b1;
          st_next.state = S_WHIGH;
        end
      end
      S_WHIGH: begin
        st_next.cnt = st_reg.cnt + 12'h001;
        if (st_reg.cnt == WPH_CYC - 12'h001) begin
          st_next.cnt = 12'h000;
          st_next.f_oe = 1'b0;
          st_next.step = nstep;
          if (st_reg.op == OP_PROG && nstep == STEP_PROG_END) begin
            st_next.state = S_BLC; // R5
          end else if (nstep == step_end(st_reg.op)) begin
            st_next.state = S_IDLE;
            st_next.ce_n = 1'b1;
            ev[IRQ_DONE] = 1'b1;
          end else begin
            st_next.state = step_is_read(st_reg.op, nstep) ? S_RLOW : S_WSET;
          end
        end
      end
      S_BLC: begin
        // Loading ends only when the device sees a gap this long
        st_next.cnt = st_reg.cnt + 12'h001;
        st_next.tmo = st_reg.tmo + 19'h1;
        if (st_reg.cnt == BLC_WAIT_CYC - 12'h001) begin // R6
          st_next.cnt = 12'h000;
          st_next.polling = 1'b1;
          st_next.f_addr = {st_reg.ctl_addr[15:SECT_LSB], 7'h00}; // R9
          st_next.state = S_RLOW;
        end
      end
      S_RLOW: begin
        st_next.cnt = st_reg.cnt + 12'h001;
        st_next.tmo = st_reg.polling ? st_reg.tmo + 19'h1 : st_reg.tmo;
        st_next.oe_n = 1'b0; // R7
        if (!st_reg.polling && st_reg.cnt == 12'h000) begin
          st_next.f_addr = (st_reg.op == OP_READ) ? st_reg.ctl_addr :
                           {15'h0000, st_reg.step == STEP_ID_PART}; // R11
        end
        if (st_reg.cnt == RD_CYC) begin
          sample = 1'b1;
          st_next.cnt = 12'h000;
          st_next.oe_n = 1'b1;
          st_next.state = S_RHIGH;
        end
      end
      S_RHIGH: begin
        st_next.cnt = st_reg.cnt + 12'h001;
        st_next.tmo = st_reg.polling ? st_reg.tmo + 19'h1 : st_reg.tmo;
        if (st_reg.cnt == OEHP_CYC - 12'h001) begin
          st_next.cnt = 12'h000;
          if (st_reg.polling) begin
            // Done once two reads agree; the level itself means nothing
            if (st_reg.have_prev && (st_reg.prev_t == st_reg.rbyte[TOGGLE_BIT])) begin // R8
              st_next.state = S_IDLE;
              st_next.polling = 1'b0;
              st_next.ce_n = 1'b1;
              ev[IRQ_DONE] = 1'b1;
            end else if (32'(st_reg.tmo) >= PROG_TIMEOUT_CYC) begin
              st_next.state = S_IDLE;
              st_next.polling = 1'b0;
              st_next.ce_n = 1'b1;
              ev[IRQ_TMO] = 1'b1;
            end else begin
              st_next.state = S_RLOW; // R7
            end
            st_next.have_prev = 1'b1;
            st_next.prev_t = st_reg.rbyte[TOGGLE_BIT];
          end else begin
            st_next.step = nstep;
            if (nstep == step_end(st_reg.op)) begin
              st_next.state = S_IDLE;
              st_next.ce_n = 1'b1;
              ev[IRQ_DONE] = 1'b1;
            end else begin
              st_next.state = step_is_read(st_reg.op, nstep) ? S_RLOW : S_WSET;
            end
          end
        end
      end
    endcase
    if (sample) begin
      if (st_reg.op == OP_ID && st_reg.step == STEP_ID_MAKER) begin
        st_next.maker = flash_dq_i;
      end else if (st_reg.op == OP_ID) begin
        st_next.part = flash_dq_i;
      end else begin
        st_next.rbyte = flash_dq_i;
      end
    end

    // Sticky events, set beats a same-cycle clear
    if (acc_wr && paddr == REG_ISTAT) begin
      st_next.istat = st_reg.istat & ~pwdata[2:0];
    end
    st_next.istat = st_next.istat | ev;
    st_next.irq = |(st_next.istat & st_next.imask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{state: S_IDLE, op: OP_NONE, imask: IMASK_RESET,
                  ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign irq = st_reg.irq;
  assign flash_addr = st_reg.f_addr;
  assign flash_dq_o = st_reg.f_dq;
  assign flash_dq_oe = st_reg.f_oe;
  assign flash_ce_n = st_reg.ce_n;
  assign flash_oe_n = st_reg.oe_n;
  assign flash_we_n = st_reg.we_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [11:0] gap_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_cnt <= 12'h000;
    end else if (clk_en) begin
      gap_cnt <= (st_reg.we_n && !st_next.we_n) ? 12'h000 : gap_cnt + 12'h001;
    end
  end

  chk_oe_during_write: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (!flash_we_n && !flash_ce_n) |-> flash_oe_n)
    else $error("output enable low during write strobe");

  chk_sector_addr_hold: assert property (@(posedge pclk) disable iff (!presetn) // R2
    ($fell(flash_we_n) && st_reg.op == OP_PROG && st_reg.step >= STEP_DATA0)
      |-> flash_addr[15:SECT_LSB] == st_reg.ctl_addr[15:SECT_LSB])
    else $error("sector address differs at strobe fall");

  chk_full_load_count: assert property (@(posedge pclk) disable iff (!presetn) // R5
    (st_reg.state == S_BLC && $past(st_reg.state) == S_WHIGH)
      |-> st_reg.step == STEP_PROG_END)
    else $error("program started without a full sector load");

  chk_load_gap_bound: assert property (@(posedge pclk) disable iff (!presetn) // R6
    ($fell(flash_we_n) && st_reg.op == OP_PROG && st_reg.step > 8'h00)
      |-> $past(gap_cnt) < BLC_GAP_CYC)
    else $error("byte load gap exceeded load timeout");

  chk_poll_oe_pulse: assert property (@(posedge pclk) disable iff (!presetn) // R7
    ($rose(flash_oe_n) && st_reg.polling && clk_en) |-> flash_oe_n [*3])
    else $error("poll output enable high pulse too short");

  chk_done_two_reads: assert property (@(posedge pclk) disable iff (!presetn) // R8
    ($fell(st_reg.polling) && $past(st_reg.state) == S_RHIGH)
      |-> $past(st_reg.have_prev))
    else $error("completion declared from a single read");

  chk_poll_addr_fixed: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (st_reg.polling && $past(st_reg.polling)) |-> $stable(flash_addr))
    else $error("poll address changed");

  chk_no_write_polling: assert property (@(posedge pclk) disable iff (!presetn) // R15
    (st_reg.polling || st_reg.state == S_BLC) |-> (flash_we_n && !flash_dq_oe))
    else $error("flash access issued before completion");

endmodule : sfpp_ctrl

// >>> shared/sfpp_pkg.sv
/*
  Constants, types and register map of the sector flash program controller.
  Assumes a 25 MHz pclk; every cycle count below except SET_CYC is derived from that rate.
*/
package sfpp_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int T_WP_NS = 200;
  localparam int T_WPH_NS = 200;
  localparam int T_ACC_NS = 120;
  localparam int T_OEHP_NS = 150;
  localparam int LOAD_GAP_US = 150;
  localparam int PROG_MAX_MS = 20;
  localparam int SET_CYC_I = 2;
  localparam logic [11:0] SET_CYC = 12'(SET_CYC_I);
  localparam logic [11:0] WP_CYC = 12'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] WPH_CYC = 12'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
  // One extra cycle because the data pins are registered before use
  localparam logic [11:0] RD_CYC = 12'((T_ACC_NS + CLK_NS - 1) / CLK_NS + 1);
  localparam logic [11:0] OEHP_CYC = 12'((T_OEHP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] BLC_WAIT_CYC = 12'((LOAD_GAP_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] BLC_GAP_CYC = 12'((LOAD_GAP_US * 1000) / CLK_NS);
  localparam int TWC_CYC = (PROG_MAX_MS * 1000000) / CLK_NS;

  // ----------------------------------------------------------------
  // Flash command sequences
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_ADDR_A = 16'h5555;
  localparam logic [15:0] CMD_ADDR_B = 16'h2AAA;
  localparam logic [7:0] CMD_UNLOCK_A = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK_B = 8'h55;
  localparam logic [7:0] CMD_PROTECT = 8'hA0;
  localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0] CMD_ID_EXIT = 8'hF0;
  localparam int SECTOR_BYTES = 128;
  localparam int SECT_LSB = 7;
  localparam int TOGGLE_BIT = 6;
  localparam logic [7:0] STEP_DATA0 = 8'h03;
  localparam logic [7:0] STEP_PROG_END = 8'(3 + SECTOR_BYTES);
  localparam logic [7:0] STEP_ID_MAKER = 8'h03;
  localparam logic [7:0] STEP_ID_PART = 8'h04;
  localparam logic [7:0] STEP_ID_END = 8'h08;
  localparam logic [7:0] STEP_RD_END = 8'h01;

  // ----------------------------------------------------------------
  // Register map, one 32-bit word each
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_BUFDATA = 8'h08;
  localparam logic [7:0] REG_BUFIDX = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam logic [7:0] REG_ISTAT = 8'h18;
  localparam logic [7:0] REG_IMASK = 8'h1C;
  localparam logic [1:0] OPC_PROG = 2'h1;
  localparam logic [1:0] OPC_ID = 2'h2;
  localparam logic [1:0] OPC_READ = 2'h3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TMO = 1;
  localparam int IRQ_REFUSED = 2;
  localparam logic [2:0] IMASK_RESET = 3'h0;

  typedef enum logic [2:0] {
    S_IDLE, S_WSET, S_WLOW, S_WHIGH, S_RLOW, S_RHIGH, S_BLC
  } sfpp_state_e;

  typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_ID, OP_READ} sfpp_op_e;

endpackage : sfpp_pkg

// >>> verification/sfpp_ctrl_bench.sv
/*
  Self-checking bench of the flash controller: APB tasks and scenarios.
  Assumes the flash model beside it; pready answers without wait states.
*/
`timescale 1ns/1ps
module sfpp_ctrl_bench
  import sfpp_pkg::*;
;
  localparam logic [15:0] SECT = 16'h1280;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic hang = 1'b0, run = 1'b1, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, ce_n, oe_n, we_n, dq_oe;
  logic [15:0] fa;
  logic [7:0] dq_o, dq_i;
  int viol, bad_count = 0, compares = 0;

  always #20 pclk = ~pclk;

  sfpp_ctrl #(.PROG_TIMEOUT_CYC(20000)) sfpp_ctrl_i (.pclk(pclk), .presetn(presetn),
    .clk_en(run), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .flash_addr(fa), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n));

  sfpp_flash_model #(.PROG_CYC(2000)) sfpp_flash_model_i (.pclk(pclk), .presetn(presetn),
    .flash_addr(fa), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .hang_busy(hang), .flash_dq_i(dq_i),
    .viol(viol));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] exp_b(input int i);
    return 8'(i * 3 + 1);
  endfunction : exp_b

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      bad_count++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask : rdchk

  // Bounded poll of the busy flag; a hang ends the run
  task automatic wait_idle;
    for (int i = 0; i < 20000; i++) begin
      xfer(1'b0, REG_STATUS, 32'h0);
      if (rd[0] === 1'b0) return;
    end
    bad_count++;
    tally_and_finish();
  endtask : wait_idle

  task automatic rd_byte(input logic [15:0] a, input logic [7:0] e);
    xfer(1'b1, REG_ADDR, {16'h0, a});
    xfer(1'b1, REG_CMD, {30'h0, OPC_READ});
    wait_idle();
    rdchk(REG_RDATA, 32'hFF, {24'h0, e});
  endtask : rd_byte

  task automatic irq_is(input logic e);
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, {31'h0, e});
  endtask : irq_is

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(REG_IMASK, 32'hFFFFFFFF, 32'h0);
    rdchk(REG_ISTAT, 32'hFFFFFFFF, 32'h0);
    rdchk(REG_STATUS, 32'hFFFFFFFF, 32'h0);
    rdchk(8'h20, 32'hFFFFFFFF, 32'h0);
    check({31'h0, err}, 32'h1);
    // Operation code zero is refused; the sticky bit clears on a written one
    xfer(1'b1, REG_CMD, 32'h0);
    rdchk(REG_ISTAT, 32'h7, 32'h4);
    xfer(1'b1, REG_ISTAT, 32'h4);
    rdchk(REG_ISTAT, 32'h7, 32'h0);
    xfer(1'b1, REG_IMASK, 32'h7);
    rdchk(REG_IMASK, 32'h7, 32'h7);
    xfer(1'b1, REG_ADDR, {16'h0, SECT});
    xfer(1'b1, REG_BUFIDX, 32'h0);
    for (int i = 0; i < SECTOR_BYTES; i++) xfer(1'b1, REG_BUFDATA, {24'h0, exp_b(i)});
    rdchk(REG_BUFIDX, 32'h7F, 32'h0);
    xfer(1'b1, REG_CMD, {30'h0, OPC_PROG});
    rdchk(REG_STATUS, 32'h3, 32'h3);
    // Command while busy is refused and must not touch the flash pins
    xfer(1'b1, REG_CMD, {30'h0, OPC_ID});
    rdchk(REG_ISTAT, 32'h4, 32'h4);
    irq_is(1'b1);
    xfer(1'b1, REG_ISTAT, 32'h4);
    // Clock enable low must freeze every pin but flash_dq_oe in mid-operation
    run <= 1'b0;
    @(posedge pclk);
    rd = {5'h0, fa, dq_o, ce_n, oe_n, we_n};
    repeat (20) @(posedge pclk);
    check({5'h0, fa, dq_o, ce_n, oe_n, we_n}, rd);
    run <= 1'b1;
    wait_idle();
    rdchk(REG_ISTAT, 32'h7, 32'h1);
    irq_is(1'b1);
    xfer(1'b1, REG_ISTAT, 32'h1);
    irq_is(1'b0);
    rd_byte({SECT[15:7], 7'h00}, exp_b(0));
    rd_byte({SECT[15:7], 7'h01}, exp_b(1));
    rd_byte({SECT[15:7], 7'h7F}, exp_b(127));
    xfer(1'b1, REG_IMASK, 32'h0);
    xfer(1'b1, REG_ISTAT, 32'h7);
    xfer(1'b1, REG_CMD, {30'h0, OPC_ID});
    wait_idle();
    rdchk(REG_RDATA, 32'h00FFFF00, {8'h0, 8'h6B, 8'hC4, 8'h0});
    rdchk(REG_ISTAT, 32'h1, 32'h1);
    irq_is(1'b0);
    rd_byte({SECT[15:7], 7'h05}, exp_b(5));
    // Flash that never finishes: poll timeout must end the operation
    hang <= 1'b1;
    xfer(1'b1, REG_IMASK, 32'h2);
    xfer(1'b1, REG_ISTAT, 32'h7);
    xfer(1'b1, REG_ADDR, 32'h0400);
    xfer(1'b1, REG_CMD, {30'h0, OPC_PROG});
    wait_idle();
    rdchk(REG_ISTAT, 32'h2, 32'h2);
    irq_is(1'b1);
    check(32'(viol), 32'h0);
    tally_and_finish();
  end
endmodule : sfpp_ctrl_bench

// >>> verification/sfpp_flash_model.sv
/*
  Behavioural byte-wide sector flash on the far side of the controller.
  Assumes pins change only at pclk edges; of the counts only viol is reset by presetn.
*/
`timescale 1ns/1ps
module sfpp_flash_model
  import sfpp_pkg::*;
#(
  parameter int PROG_CYC = 2000,
  // Identity values are arbitrary
  parameter logic [7:0] MAKER_CODE = 8'hC4,
  parameter logic [7:0] PART_CODE = 8'h6B
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] flash_addr,
  input wire logic [7:0] flash_dq_o,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic hang_busy,
  output logic [7:0] flash_dq_i,
  output int viol
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] mem [0:65535];
  logic [7:0] page [0:127];
  logic [127:0] loaded;
  logic [8:0] sec;
  logic [15:0] poll_addr;
  logic [7:0] rd_val, last_out;
  logic [1:0] step;
  logic we_d, oe_d, loading, id_mode, busy, last7, tog, poll_set;
  int nload, gap, cnt;
  wire fall_we = we_d && !flash_we_n && !flash_ce_n;

  // ----------------------------------------------------------------
  // Device behaviour
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {we_d, oe_d} <= 2'h3;
      {loading, busy, tog, poll_set, last7} <= 5'h0;
      id_mode <= 1'b0;
      step <= 2'h0;
      last_out <= 8'h00;
      viol = 0;
    end else begin
      we_d <= flash_we_n;
      oe_d <= flash_oe_n;
      if (!flash_we_n && !flash_ce_n && !flash_oe_n) viol = viol + 1;
      if (!flash_ce_n && !flash_oe_n) last_out <= rd_val;
      if (fall_we && busy) viol = viol + 1;
      else if (fall_we && loading) begin
        if (nload != 0 && flash_addr[15:7] !== sec) viol = viol + 1;
        sec <= flash_addr[15:7];
        page[flash_addr[6:0]] <= flash_dq_o;
        loaded[flash_addr[6:0]] <= 1'b1;
        last7 <= flash_dq_o[7];
        nload <= nload + 1;
        gap <= 0;
      end else if (fall_we) begin
        case (step)
          2'h0: step <= (flash_addr == CMD_ADDR_A && flash_dq_o == CMD_UNLOCK_A) ? 2'h1 : 2'h0;
          2'h1: step <= (flash_addr == CMD_ADDR_B && flash_dq_o == CMD_UNLOCK_B) ? 2'h2 : 2'h0;
          default: begin
            step <= 2'h0;
            if (flash_addr == CMD_ADDR_A && flash_dq_o == CMD_PROTECT) begin
              {loading, nload, gap, loaded} <= {1'b1, 32'h0, 32'h0, 128'h0};
            end
            if (flash_addr == CMD_ADDR_A && flash_dq_o == CMD_ID_ENTRY) id_mode <= 1'b1;
            if (flash_addr == CMD_ADDR_A && flash_dq_o == CMD_ID_EXIT) id_mode <= 1'b0;
          end
        endcase
      end
      if (loading && !fall_we) gap <= gap + 1;
      if (loading && gap >= int'(BLC_GAP_CYC)) begin
        loading <= 1'b0;
        busy <= 1'b1;
        cnt <= 0;
        poll_set <= 1'b0;
        if (nload != SECTOR_BYTES) viol = viol + 1;
      end
      if (busy) begin
        if (!hang_busy) cnt <= cnt + 1;
        // Erase and program at once; the protect state is gone with loading
        if (cnt >= PROG_CYC) begin
          busy <= 1'b0;
          for (int i = 0; i < SECTOR_BYTES; i++) begin
            mem[{sec, 7'(i)}] <= loaded[i] ? page[i] : 8'hXX;
          end
        end
        if (oe_d && !flash_oe_n && !flash_ce_n) begin
          tog <= ~tog;
          if (poll_set && flash_addr !== poll_addr) viol = viol + 1;
          poll_addr <= flash_addr;
          poll_set <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data; released bus shows the inverse of the last byte
  // ----------------------------------------------------------------
  assign rd_val = busy ? {~last7, tog, 6'h00} :
    (id_mode && flash_addr[15:1] == 15'h0000) ? (flash_addr[0] ? PART_CODE : MAKER_CODE) :
    mem[flash_addr];
  assign flash_dq_i = (!flash_ce_n && !flash_oe_n && !flash_dq_oe) ? rd_val : ~last_out;
endmodule : sfpp_flash_model
